// ===== bench/sfis_checker.sv
// Assertions on the ports of the flash interface state block.
module sfis_checker (
   // Watched ports
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_i,
   input wire logic [3:0] io_oe_n,
   input wire logic ready,
   input wire logic warm_reset_busy,
   input wire logic hold_active,
   input wire sfis_pkg::sfis_state_t iface_state,
   input wire logic commit_valid
);
   import sfis_pkg::*;
   sequence pulse_s;
      commit_valid ##1 !commit_valid;
   endsequence
   unready_a: assert property (@(posedge clk) disable iff (rst) !ready |-> io_oe_n == 4'hf)
      else $error("pins driven while not ready");
   standby_a: assert property (@(posedge clk) disable iff (rst) cs_n |-> io_oe_n == 4'hf)
      else $error("pins driven in standby");
   pause_float_a: assert property (@(posedge clk) disable iff (rst) hold_active |-> &io_oe_n[1:0])
      else $error("pins driven in pause");
   pause_freeze_a: assert property (@(posedge sck) disable iff (rst || cs_n || !ready)
      hold_active |-> !io_i[3] ##1 $stable(iface_state)) else $error("state moved in pause");
   commit_one_a: assert property (@(posedge clk) disable iff (rst) commit_valid |-> ready ##0 pulse_s)
      else $error("bad commit pulse");
   warm_busy_a: assert property (@(posedge clk) disable iff (rst) warm_reset_busy |-> !ready)
      else $error("ready during warm reset");
   input_float_a: assert property (@(posedge sck) disable iff (rst || cs_n || !ready)
      iface_state inside {ST_INSTR, ST_SIN} |-> io_oe_n == 4'hf) else $error("driven in input cycle");
   dummy_float_a: assert property (@(posedge sck) disable iff (rst || cs_n || !ready)
      iface_state == ST_LAT |-> io_oe_n == 4'hf) else $error("driven in dummy cycle");
   single_out_a: assert property (@(posedge sck) disable iff (rst || cs_n || !ready)
      iface_state == ST_SOUT && !hold_active |-> io_oe_n == 4'hd) else $error("bad single output");
endmodule
bind sfis_top sfis_checker chk_i (.clk, .rst, .sck, .cs_n, .io_i, .io_oe_n, .ready, .warm_reset_busy,
   .hold_active, .iface_state, .commit_valid);

// ===== bench/sfis_host.sv
// Behavioural host controller that drives the link of the flash interface block.
module sfis_host (
   // Link pins
   output logic sck,
   output logic cs_n,
   output logic [3:0] ho,
   output logic [3:0] hen,
   input wire logic [3:0] io
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck = 0;
      cs_n = 1;
      ho = 4'hf;
      hen = 4'hc;
   end
   // Sends n bits on IO0, clocks m more edges with IO0 released, pauses before edge p.
   task automatic frame(input logic [31:0] b, input int n, m, p, output logic [7:0] rd);
      rd = '0;
      cs_n = 0;
      hen[0] = 1;
      for (int i = 0; i < n + m; i++) begin
         if (i < n) ho[0] = b[31 - i];
         else hen[0] = 0;
         if (i == p) begin
            ho[3] = 0;
            repeat (4) #6 sck = ~sck;
            ho[3] = 1;
         end
         #6 sck = 1;
         rd = {rd[6:0], io[1]};
         #6 sck = 0;
      end
      #6 cs_n = 1;
      hen[0] = 0;
      #30;
   endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the flash interface state block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfis_pkg::*;
   logic clk = 0, rst = 1, reset_n = 1, supply_good = 1, supply_ok = 1, quad_enable = 0, io3_function_select = 0;
   logic tog = 0, sck, cs_n, ready, warm_reset_busy, hold_active, commit_valid;
   logic [1:0] latency_code = 0;
   logic [7:0] rd_byte = 0, rd;
   logic [3:0] io_i, io_o, io_oe_n, ho, hen;
   sfis_state_t iface_state;
   sfis_cmd_t commit, last;
   int err_count = 0, tests_run = 0, seen = 0, cyc = 0, n;
   int dum[4] = '{LAT_CODE0, LAT_CODE1, LAT_CODE2, LAT_CODE3};
   sfis_top #(.POWER_UP_CYCLES(20), .RESET_PROC_CYCLES(10)) uut (.clk, .rst, .sck, .cs_n, .io_i, .io_o, .io_oe_n,
      .reset_n, .supply_good, .supply_ok, .quad_enable, .latency_code, .io3_function_select, .rd_byte, .ready,
      .warm_reset_busy, .hold_active, .iface_state, .commit_valid, .commit);
   sfis_host host (.sck, .cs_n, .ho, .hen, .io(io_i));
   // IO2 and IO3 are pulled up; a released IO0 or IO1 toggles so stale data never reads back.
   always_comb for (int k = 0; k < 4; k++) io_i[k] = !io_oe_n[k] ? io_o[k] : hen[k] ? ho[k] : k > 1 || tog;
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      tog <= ~tog;
      cyc++;
      if (commit_valid === 1'b1) begin
         seen++;
         last = commit;
      end
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [39:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_ready(output int w);
      w = 0;
      while (ready !== 1'b1 && w < 300) begin
         @(negedge clk);
         w++;
      end
      chk("ready", ready, 1);
   endtask
   task automatic t_read(input logic [7:0] op, input logic [1:0] lat, input int d, p);
      @(negedge clk);
      latency_code = lat;
      rd_byte = op ^ 8'h96;
      host.frame({op, 24'h123456}, 32, d + 8, p, rd);
      chk("read", rd, rd_byte);
      chk("state", iface_state, ST_STANDBY);
      $display("read test done");
   endtask
   task automatic t_quad(input logic [1:0] lat, input int d);
      @(negedge clk);
      quad_enable = 1;
      latency_code = lat;
      rd_byte = 8'h2d;
      host.hen = 4'h0;
      host.frame({OP_FOUR_LINE_OUTPUT_READ, 24'h654321}, 32, d + 8, 99, rd);
      chk("quad read", rd, {4{rd_byte[5], rd_byte[1]}});
      host.hen = 4'hc;
      quad_enable = 0;
      $display("quad read test done");
   endtask
   task automatic t_commit(input logic [7:0] op, input int b, input logic ok, wp, input int e);
      int s;
      @(negedge clk);
      supply_ok = ok;
      host.ho[2] = wp;
      s = seen;
      repeat (8) @(negedge clk);
      host.frame({op, 24'habcdef}, b, 0, 99, rd);
      repeat (12) @(negedge clk);
      chk("commits", 40'(seen - s), 40'(e));
      if (e > 0) chk("cmd", {last.opcode, last.wp_asserted}, {op, op == OP_REGISTER_WRITE_CMD && !wp});
      supply_ok = 1;
      host.ho[2] = 1;
      wait_ready(s);
      $display("commit test done");
   endtask
   task automatic t_warm(input logic sel, input int w);
      @(negedge clk);
      io3_function_select = sel;
      if (sel) host.ho[3] = 0;
      else reset_n = 0;
      repeat (w) @(negedge clk);
      chk("busy", warm_reset_busy, w > 45);
      host.ho[3] = 1;
      reset_n = 1;
      repeat (5) @(negedge clk);
      chk("warm ready", ready, w < 45);
      wait_ready(n);
      io3_function_select = 0;
      $display("warm reset test done");
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 0;
      repeat (4) @(negedge clk);
      chk("early ready", ready, 0);
      chk("early pins", io_oe_n, 4'hf);
      wait_ready(n);
      chk("power up", n inside {[16:40]}, 1);
      $display("power up test done");
      t_read(OP_READ, 0, 0, 35);
      for (int c = 0; c < 4; c++) t_read(OP_FAST_READ, c[1:0], dum[c], 20 + 5 * c);
      t_quad(2'h2, LAT_CODE2);
      t_commit(OP_SECTOR_ERASE, 32, 1, 1, 1);
      t_commit(OP_SECTOR_ERASE, 31, 1, 1, 0);
      t_commit(OP_SECTOR_ERASE, 32, 0, 1, 0);
      t_commit(OP_REGISTER_WRITE_CMD, 16, 1, 0, 1);
      t_commit(OP_SECTOR_ERASE, 32, 1, 0, 1);
      t_warm(0, 50);
      t_warm(1, 50);
      t_warm(0, 30);
      test_done();
   end
endmodule

// ===== inc/sfis_pkg.sv
// Shared constants and types of the flash interface state block.
package sfis_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int POWER_UP_NS = 300000;
   localparam int RESET_PULSE_NS = 200;
   localparam int RESET_PROC_NS = 35000;
   localparam int RESET_HOLD_NS = 50;
   localparam int POWER_UP_CYC = (POWER_UP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_PROC_CYC = (RESET_PROC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TCNT_W = 20;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int ADDR_BITS = 24;
   localparam int DATA_W = 8;
   localparam logic [5:0] INSTR_LAST = 6'h07;
   localparam logic [5:0] SIN_ADDR_LAST = 6'h17;
   localparam logic [5:0] DIN_ADDR_LAST = 6'h0f;
   localparam logic [5:0] DIN_MODE_CYC = 6'h04;
   localparam logic [5:0] QIN_ADDR_LAST = 6'h07;
   localparam logic [5:0] QIN_MODE_CYC = 6'h02;
   localparam logic [5:0] LAT_CODE0 = 6'h08;
   localparam logic [5:0] LAT_CODE1 = 6'h06;
   localparam logic [5:0] LAT_CODE2 = 6'h04;
   localparam logic [5:0] LAT_CODE3 = 6'h00;
   localparam logic [2:0] PULSE_INIT = 3'h1;

   // ---------------------------------------------------------------
   // Instructions
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
   localparam logic [7:0] OP_FOUR_LINE_OUTPUT_READ = 8'h6b;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_FOUR_LINE_PAGE_PROGRAM = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
   localparam logic [7:0] OP_REGISTER_WRITE_CMD = 8'h01;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_STANDBY, ST_INSTR, ST_SIN, ST_DIN, ST_QADDR, ST_QIN,
      ST_LAT, ST_SOUT, ST_DOUT, ST_QOUT, ST_DONE
   } sfis_state_t;

   typedef enum logic [3:0] {
      FMT_NONE, FMT_READ, FMT_FAST, FMT_DOUT, FMT_QOUT, FMT_DIO,
      FMT_QIO, FMT_PROG, FMT_QPP, FMT_ERASE, FMT_REGW
   } sfis_fmt_t;

   typedef enum logic {W_IDLE, W_PROC} sfis_warm_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [ADDR_BITS-1:0] addr;
      logic wp_asserted;
   } sfis_cmd_t;

endpackage

// ===== verilog/sfis_top.sv
// Interface state machine of a multi-line serial flash host port.

// ---------------------------------------------------------------
// Input synchroniser, three stages, change taken on agreement
// ---------------------------------------------------------------
module sfis_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// ---------------------------------------------------------------
// Top level
// ---------------------------------------------------------------
module sfis_top #(
   parameter int POWER_UP_CYCLES = sfis_pkg::POWER_UP_CYC,
   parameter int RESET_PROC_CYCLES = sfis_pkg::RESET_PROC_CYC
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_n,
   // Warm reset pin and supply monitors
   input wire logic reset_n,
   input wire logic supply_good,
   input wire logic supply_ok,
   // Configuration
   input wire logic quad_enable,
   input wire logic [1:0] latency_code,
   input wire logic io3_function_select,
   // Read data source
   input wire logic [sfis_pkg::DATA_W-1:0] rd_byte,
   // Status
   output logic ready,
   output logic warm_reset_busy,
   output logic hold_active,
   output sfis_pkg::sfis_state_t iface_state,
   // Completed write-class command
   output logic commit_valid,
   output sfis_pkg::sfis_cmd_t commit
);
   import sfis_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers in the system domain
   // ---------------------------------------------------------------
   logic rst_pin_s;
   logic io3_s;
   logic cs_s;
   logic good_s;
   logic ok_s;

   sfis_sync3 #(
      .W(5),
      .INIT(5'h1c)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({reset_n, io_i[3], cs_n, supply_good, supply_ok}),
      .q({rst_pin_s, io3_s, cs_s, good_s, ok_s})
   );

   // ---------------------------------------------------------------
   // Power-on interval
   // ---------------------------------------------------------------
   logic [TCNT_W-1:0] por_cnt_q;
   logic por_done;

   assign por_done = (por_cnt_q == TCNT_W'(POWER_UP_CYCLES));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         por_cnt_q <= '0;
      end else if (!good_s) begin
         por_cnt_q <= '0;
      end else if (!por_done) begin
         por_cnt_q <= por_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Warm reset
   // ---------------------------------------------------------------
   logic warm_low;
   logic [TCNT_W-1:0] low_cnt_q;
   logic [TCNT_W-1:0] proc_cnt_q;
   logic [TCNT_W-1:0] hold_cnt_q;
   sfis_warm_t wst_q;
   logic pulse_ok;
   logic proc_done;
   logic hold_done;

   // IO3 counts only outside quad frames.
   assign warm_low = !rst_pin_s || (io3_function_select && !io3_s && (!quad_enable || cs_s));
   assign pulse_ok = (low_cnt_q == TCNT_W'(RESET_PULSE_CYC));
   assign proc_done = (proc_cnt_q == TCNT_W'(RESET_PROC_CYCLES));
   assign hold_done = (hold_cnt_q == TCNT_W'(RESET_HOLD_CYC));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_q <= '0;
      end else if (!warm_low) begin
         low_cnt_q <= '0;
      end else if (!pulse_ok) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wst_q <= W_IDLE;
         proc_cnt_q <= '0;
         hold_cnt_q <= '0;
      end else begin
         unique case (wst_q)
            W_IDLE: begin
               proc_cnt_q <= '0;
               hold_cnt_q <= '0;
               if (pulse_ok) begin
                  wst_q <= W_PROC;
               end
            end
            W_PROC: begin
               if (!proc_done) begin
                  proc_cnt_q <= proc_cnt_q + 1'b1;
               end
               if (warm_low) begin
                  hold_cnt_q <= '0;
               end else if (!hold_done) begin
                  hold_cnt_q <= hold_cnt_q + 1'b1;
               end
               if (proc_done && hold_done && !warm_low) begin
                  wst_q <= W_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Command acceptance
   // ---------------------------------------------------------------
   logic accept_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accept_q <= 1'b0;
      end else begin
         // A qualified warm pulse drops acceptance in the same cycle that starts the process.
         accept_q <= por_done && (wst_q == W_IDLE) && !pulse_ok && ok_s;
      end
   end

   assign ready = accept_q;
   assign warm_reset_busy = (wst_q == W_PROC);

   // The link logic is held in reset while not accepting, so every
   // pin floats and no edge is seen; chip select high ends the frame.
   logic dev_rst;
   logic link_rst;

   assign dev_rst = !accept_q;
   assign link_rst = cs_n || dev_rst;

   // ---------------------------------------------------------------
   // Configuration crossing into the link domain
   // ---------------------------------------------------------------
   logic [2:0] cfg_m_q;
   logic [2:0] cfg_s_q;
   logic qe_l;
   logic [1:0] lat_code_l;

   always_ff @(posedge sck or posedge dev_rst) begin
      if (dev_rst) begin
         cfg_m_q <= 3'h0;
         cfg_s_q <= 3'h0;
      end else begin
         cfg_m_q <= {quad_enable, latency_code};
         cfg_s_q <= cfg_m_q;
      end
   end

   assign qe_l = cfg_s_q[2];
   assign lat_code_l = cfg_s_q[1:0];

   // ---------------------------------------------------------------
   // Link decode helpers
   // ---------------------------------------------------------------
   function automatic sfis_fmt_t decode(input logic [7:0] op, input logic qe);
      sfis_fmt_t f;
      f = FMT_NONE;
      unique case (op)
         OP_READ: f = FMT_READ;
         OP_FAST_READ: f = FMT_FAST;
         OP_DUAL_OUT_READ: f = FMT_DOUT;
         OP_DUAL_IO_READ: f = FMT_DIO;
         OP_FOUR_LINE_OUTPUT_READ: f = qe ? FMT_QOUT : FMT_NONE;
         OP_QUAD_IO_READ: f = qe ? FMT_QIO : FMT_NONE;
         OP_FOUR_LINE_PAGE_PROGRAM: f = qe ? FMT_QPP : FMT_NONE;
         OP_PAGE_PROGRAM: f = FMT_PROG;
         OP_SECTOR_ERASE: f = FMT_ERASE;
         OP_REGISTER_WRITE_CMD: f = FMT_REGW;
         default: f = FMT_NONE;
      endcase
      return f;
   endfunction

   function automatic logic [5:0] lat_of(input logic [1:0] code);
      logic [5:0] n;
      n = LAT_CODE0;
      unique case (code)
         2'h0: n = LAT_CODE0;
         2'h1: n = LAT_CODE1;
         2'h2: n = LAT_CODE2;
         2'h3: n = LAT_CODE3;
      endcase
      return n;
   endfunction

   function automatic sfis_state_t out_of(input sfis_fmt_t f);
      sfis_state_t s;
      s = ST_SOUT;
      if (f == FMT_DOUT || f == FMT_DIO) begin
         s = ST_DOUT;
      end else if (f == FMT_QOUT || f == FMT_QIO) begin
         s = ST_QOUT;
      end
      return s;
   endfunction

   // ---------------------------------------------------------------
   // Link state machine
   // ---------------------------------------------------------------
   sfis_state_t state_q;
   sfis_state_t state_d;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic data_q;
   logic data_d;
   sfis_fmt_t fmt_q;
   sfis_fmt_t fmt_new;
   logic [7:0] opc_q;
   logic [7:0] opc_full;
   logic paused;
   logic [5:0] lat_n;

   // With quad off, IO3 low freezes every link register except the configuration stages and the falling-edge pin drivers as if the clock had stopped.
   assign paused = !qe_l && !io_i[3];
   assign opc_full = {opc_q[6:0], io_i[0]};
   assign fmt_new = decode(opc_full, qe_l);
   assign lat_n = lat_of(lat_code_l);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      data_d = data_q;
      unique case (state_q)
         ST_STANDBY: begin
            state_d = ST_INSTR;
            cnt_d = INSTR_LAST - 6'h01;
         end
         ST_INSTR: begin
            if (cnt_q != 6'h00) begin
               cnt_d = cnt_q - 6'h01;
            end else begin
               unique case (fmt_new)
                  FMT_READ, FMT_FAST, FMT_DOUT, FMT_PROG, FMT_ERASE: begin
                     state_d = ST_SIN;
                     cnt_d = SIN_ADDR_LAST;
                  end
                  FMT_DIO: begin
                     state_d = ST_DIN;
                     cnt_d = DIN_ADDR_LAST;
                  end
                  FMT_QIO: begin
                     state_d = ST_QIN;
                     cnt_d = QIN_ADDR_LAST;
                  end
                  FMT_QOUT, FMT_QPP: begin
                     state_d = ST_QADDR;
                     cnt_d = SIN_ADDR_LAST;
                  end
                  FMT_REGW: begin
                     state_d = ST_SIN;
                     data_d = 1'b1;
                  end
                  FMT_NONE: begin
                     state_d = ST_DONE;
                  end
               endcase
            end
         end
         ST_SIN, ST_DIN, ST_QADDR, ST_QIN: begin
            if (data_q) begin
               state_d = state_q;
            end else if (cnt_q != 6'h00) begin
               cnt_d = cnt_q - 6'h01;
            end else begin
               unique case (fmt_q)
                  FMT_PROG: data_d = 1'b1;
                  FMT_ERASE: state_d = ST_DONE;
                  FMT_QPP: begin
                     state_d = ST_QIN;
                     data_d = 1'b1;
                  end
                  FMT_READ: state_d = ST_SOUT;
                  default: begin
                     if (lat_n == 6'h00) begin
                        state_d = out_of(fmt_q);
                     end else begin
                        state_d = ST_LAT;
                        cnt_d = lat_n - 6'h01;
                     end
                  end
               endcase
            end
         end
         ST_LAT: begin
            if (cnt_q != 6'h00) begin
               cnt_d = cnt_q - 6'h01;
            end else begin
               state_d = out_of(fmt_q);
            end
         end
         ST_SOUT, ST_DOUT, ST_QOUT, ST_DONE: begin
            state_d = state_q;
         end
      endcase
   end

   always_ff @(posedge sck or posedge link_rst) begin
      if (link_rst) begin
         state_q <= ST_STANDBY;
         cnt_q <= 6'h00;
         data_q <= 1'b0;
      end else if (!paused) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         data_q <= data_d;
      end
   end

   assign iface_state = state_q;

   // ---------------------------------------------------------------
   // Captured command, kept after the frame for the system side
   // ---------------------------------------------------------------
   logic [ADDR_BITS-1:0] addr_q;
   logic [2:0] pulse_q;
   logic wr_q;
   logic wp_q;

   always_ff @(posedge sck or posedge dev_rst) begin
      if (dev_rst) begin
         opc_q <= 8'h00;
         fmt_q <= FMT_NONE;
         wr_q <= 1'b0;
         wp_q <= 1'b0;
      end else if (!cs_n && !paused) begin
         if (state_q == ST_STANDBY) begin
            opc_q <= {7'h00, io_i[0]};
            wr_q <= 1'b0;
            wp_q <= 1'b0;
         end else if (state_q == ST_INSTR) begin
            opc_q <= opc_full;
            if (cnt_q == 6'h00) begin
               fmt_q <= fmt_new;
               wr_q <= (fmt_new == FMT_PROG) || (fmt_new == FMT_QPP) || (fmt_new == FMT_ERASE) || (fmt_new == FMT_REGW);
               wp_q <= (fmt_new == FMT_REGW) && !qe_l && !io_i[2];
            end
         end
      end
   end

   always_ff @(posedge sck or posedge dev_rst) begin
      if (dev_rst) begin
         pulse_q <= 3'h0;
      end else if (!cs_n && !paused) begin
         if (state_q == ST_STANDBY) begin
            pulse_q <= PULSE_INIT;
         end else begin
            pulse_q <= pulse_q + 3'h1;
         end
      end
   end

   // Address shifting stops once the mode cycles begin; dummy and
   // data cycles never touch it.
   always_ff @(posedge sck or posedge dev_rst) begin
      if (dev_rst) begin
         addr_q <= '0;
      end else if (!cs_n && !paused && !data_q) begin
         unique case (state_q)
            ST_SIN, ST_QADDR: addr_q <= {addr_q[ADDR_BITS-2:0], io_i[0]};
            ST_DIN: begin
               if (cnt_q >= DIN_MODE_CYC) begin
                  addr_q <= {addr_q[ADDR_BITS-3:0], io_i[1:0]};
               end
            end
            ST_QIN: begin
               if (cnt_q >= QIN_MODE_CYC) begin
                  addr_q <= {addr_q[ADDR_BITS-5:0], io_i[3:0]};
               end
            end
            default: addr_q <= addr_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read data shifter and pin drivers
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_q;
   logic [3:0] out_q;
   logic [3:0] oe_n_q;
   logic is_out_q;
   logic is_out_d;

   assign is_out_q = (state_q == ST_SOUT) || (state_q == ST_DOUT) || (state_q == ST_QOUT);
   assign is_out_d = (state_d == ST_SOUT) || (state_d == ST_DOUT) || (state_d == ST_QOUT);

   always_ff @(posedge sck or posedge link_rst) begin
      if (link_rst) begin
         rd_q <= '0;
      end else if (!paused) begin
         if (is_out_d && !is_out_q) begin
            rd_q <= rd_byte;
         end else if (state_q == ST_SOUT) begin
            rd_q <= {rd_q[DATA_W-2:0], rd_q[DATA_W-1]};
         end else if (state_q == ST_DOUT) begin
            rd_q <= {rd_q[DATA_W-3:0], rd_q[DATA_W-1:DATA_W-2]};
         end else if (state_q == ST_QOUT) begin
            rd_q <= {rd_q[DATA_W-5:0], rd_q[DATA_W-1:DATA_W-4]};
         end
      end
   end

   // Pins change on the falling edge so the host samples on the rise.
   always_ff @(negedge sck or posedge link_rst) begin
      if (link_rst) begin
         out_q <= 4'h0;
         oe_n_q <= 4'hf;
      end else begin
         unique case (state_q)
            ST_SOUT: begin
               out_q <= {2'h0, rd_q[DATA_W-1], 1'b0};
               oe_n_q <= 4'hd;
            end
            ST_DOUT: begin
               out_q <= {2'h0, rd_q[DATA_W-1:DATA_W-2]};
               oe_n_q <= 4'hc;
            end
            ST_QOUT: begin
               out_q <= rd_q[DATA_W-1:DATA_W-4];
               oe_n_q <= 4'h0;
            end
            default: begin
               out_q <= 4'h0;
               oe_n_q <= 4'hf;
            end
         endcase
      end
   end

   assign hold_active = !cs_n && accept_q && paused;
   assign io_o = out_q;
   assign io_oe_n = oe_n_q | {2'h0, hold_active, hold_active};

   // ---------------------------------------------------------------
   // Hand-off of write-class commands to the system side
   // ---------------------------------------------------------------
   logic cs_prev_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_prev_q <= 1'b1;
         commit_valid <= 1'b0;
         commit <= '0;
      end else begin
         cs_prev_q <= cs_s;
         commit_valid <= 1'b0;
         if (cs_s && !cs_prev_q && accept_q && wr_q && (pulse_q == 3'h0)) begin
            commit_valid <= 1'b1;
            commit <= '{opcode: opc_q, addr: addr_q, wp_asserted: wp_q};
         end
      end
   end
endmodule
